// ==== logic/mtm_pkg.sv ====
// mtm_pkg: shared constants and types for the modem test/operate mode control
// assumes a 200 MHz hclk and an AHB-Lite register bus with 32-bit data
package mtm_pkg;

   // clock and time base
   localparam int unsigned CLK_HZ      = 200_000_000;
   localparam int unsigned MS_PER_S    = 1000;
   localparam int unsigned MS_CYCLES   = CLK_HZ / MS_PER_S;

   // times in milliseconds
   localparam logic [11:0] BLANK_MS      = 12'h096; // 150 ms
   localparam logic [11:0] AEQ_EXTRA_MS  = 12'h3D4; // 980 ms
   localparam logic [11:0] STANDBY_BACKUP_FEATURE_LONG_MS  = 12'h5DC; // 1500 ms
   localparam logic [11:0] STANDBY_BACKUP_FEATURE_SHORT_MS = 12'h01E; // 30 ms
   localparam logic [11:0] AEQ_SETTLE_MS = 12'h320; // 800 ms
   localparam logic [11:0] DIAL_QUAL_MS  = 12'hBB8; // 3000 ms

   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] SPACE_OFS  = 8'h08;

   // control field positions
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_DIAL     = 3;
   localparam int unsigned CTRL_LONG     = 4;
   localparam int unsigned CTRL_AEQ      = 5;
   localparam int unsigned CTRL_STANDBY_BACKUP_FEATURE     = 6;
   localparam int unsigned CTRL_DUPLEX   = 7;
   localparam int unsigned CTRL_R1200    = 8;
   localparam int unsigned CTRL_CTS_LSB  = 16;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK     = 32'h00FF_01FF;

   // test/operate switch positions
   typedef enum logic [2:0] {
      MODE_OPERATE            = 3'b000,
      MODE_LOCAL_LOOP_TEST    = 3'b001,
      MODE_TERMINAL_LOOP_TEST = 3'b010,
      MODE_LINE_TRANSMIT_TEST = 3'b011,
      MODE_LINE_RECEIVE_TEST  = 3'b100
   } mtm_mode_e;

   // software-written control word
   typedef struct packed {
      logic [7:0]  cts_delay_straps;
      logic [6:0]  spare;
      logic        rate_1200;
      logic        duplex;
      logic        standby_backup_feature;
      logic        auto_equalizer;
      logic        long_initial_cts;
      logic        dial_tone_en;
      logic [2:0]  mode;
   } mtm_ctrl_s;

endpackage

// ==== logic/mtm_top.sv ====
// mtm_top: test/operate mode control for a synchronous scrambled-data modem
// assumes rx_bit/rx_bit_valid/carrier_det come from demodulator logic on hclk;
// dte pins and the dial tone detector are asynchronous and get synchronised
//
// Summary of operation
// - local loop test clamps transmit data to mark so the scrambler sends its pattern.
// - local loop test wraps the line transmitter into the receive path.
// - looped data descrambled; steady mark keeps operate indicator lit.
// - a detected space during self-check blanks the operate indicator 150 ms.
// - terminal loop test wraps the modem while the terminal keeps interface control.
// - terminal test line in operate acts like the terminal loop switch position but leaves the ready indicator lit.
// - line transmit test clamps data to mark and sends the pattern to the line.
// - duplex modem in line transmit test also checks received data for spaces.
// - line receive test checks the descrambled remote signal; spaces blank 150 ms.
// - duplex modem in line receive test retransmits received data, a remote loop.
// - local loop, transmit and receive tests clamp off the terminal interface.
// - equalizer off in loop modes; on in line tests except at 1200 bps.
// - enabled dial tone detect holds received data at mark; no disconnect.
// - dial tone clamps within three to ten seconds, stopping operate blinking.
// - base request-to-send to clear-to-send delay comes from configuration straps.
// - long initial cts adds 980 ms auto eq or 1500 ms standby; else standby 30 ms.
// - with auto equalizer the resync control waits an extra 800 ms before settling.
// - settled resync control level equals internal carrier detect.
// - terminal loop switch asserts data set ready but keeps ready indicator off.
`timescale 1ns/1ps
module mtm_top #(
   parameter int unsigned MS_CYCLES    = mtm_pkg::MS_CYCLES,
   parameter logic [11:0] DIAL_QUAL_MS = mtm_pkg::DIAL_QUAL_MS
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // terminal side pins
   input  wire logic        dte_rts,
   input  wire logic        dte_tx_data,
   input  wire logic        dte_test_line,
   output logic             dte_cts,
   output logic             dte_dsr,
   output logic             dte_dcd,
   output logic             dte_rx_data,
   // modem side
   input  wire logic        rx_bit,
   input  wire logic        rx_bit_valid,
   input  wire logic        carrier_det,
   input  wire logic        dial_tone_pin,
   output logic             tx_bit,
   output logic             tx_rts,
   output logic             wrap_relay,
   output logic             eq_enable,
   output logic             resync_ctrl,
   // indicators
   output logic             operate_ind,
   output logic             ready_ind
);

   localparam int unsigned NSYNC = 4;

   // pin synchronisers: three flops, accept when 2nd and 3rd agree
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1;
   logic [NSYNC-1:0] s2;
   logic [NSYNC-1:0] s3;
   logic [NSYNC-1:0] pin_q;

   assign pin_raw = {dial_tone_pin, dte_test_line, dte_tx_data, dte_rts};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               s1[gi]    <= 1'b0;
               s2[gi]    <= 1'b0;
               s3[gi]    <= 1'b0;
               pin_q[gi] <= 1'b0;
            end
            else
            begin
               s1[gi] <= pin_raw[gi];
               s2[gi] <= s1[gi];
               s3[gi] <= s2[gi];
               if (s2[gi] == s3[gi])
                  pin_q[gi] <= s3[gi];
            end
         end
      end
   endgenerate

   wire rts_in    = pin_q[0];
   wire txd_in    = pin_q[1];
   wire test_line = pin_q[2];
   wire dial_in   = pin_q[3];

   // register bus
   mtm_pkg::mtm_ctrl_s ctrl;
   logic [15:0]        space_cnt;
   logic               wr_pend;
   logic [7:0]         wr_ofs;

   wire        take     = hsel & htrans[1] & hready;
   wire [7:0]  a_ofs    = haddr[7:0];
   wire        wr_ctrl  = wr_pend & (wr_ofs == mtm_pkg::CTRL_OFS);
   wire        wr_space = wr_pend & (wr_ofs == mtm_pkg::SPACE_OFS);

   // mode decode
   mtm_pkg::mtm_mode_e sw_mode;
   mtm_pkg::mtm_mode_e mode;
   mtm_pkg::mtm_mode_e mode_q;

   always_comb
   begin
      unique case (ctrl.mode)
         3'b001:  sw_mode = mtm_pkg::MODE_LOCAL_LOOP_TEST;
         3'b010:  sw_mode = mtm_pkg::MODE_TERMINAL_LOOP_TEST;
         3'b011:  sw_mode = mtm_pkg::MODE_LINE_TRANSMIT_TEST;
         3'b100:  sw_mode = mtm_pkg::MODE_LINE_RECEIVE_TEST;
         default: sw_mode = mtm_pkg::MODE_OPERATE;
      endcase
   end

   // test line in operate behaves as the terminal loop position
   assign mode = (sw_mode == mtm_pkg::MODE_OPERATE && test_line) ?
                 mtm_pkg::MODE_TERMINAL_LOOP_TEST : sw_mode;

   wire m_local  = (mode == mtm_pkg::MODE_LOCAL_LOOP_TEST);
   wire m_term   = (mode == mtm_pkg::MODE_TERMINAL_LOOP_TEST);
   wire m_ltx    = (mode == mtm_pkg::MODE_LINE_TRANSMIT_TEST);
   wire m_lrx    = (mode == mtm_pkg::MODE_LINE_RECEIVE_TEST);
   wire sw_term  = (sw_mode == mtm_pkg::MODE_TERMINAL_LOOP_TEST);
   wire clamp    = m_local | m_ltx | m_lrx;
   wire loop     = m_local | m_term;
   wire mode_chg = (mode != mode_q);

   // millisecond tick shared by all long timers
   logic [31:0] pre_cnt;
   wire         ms_tick = (pre_cnt == MS_CYCLES - 1);

   // dial tone qualification before clamping received data
   logic [11:0] dial_ms;
   logic        dial_clamp;
   wire         dial_active = ctrl.dial_tone_en & dial_in;
   // between strobes the demodulator bit is not data; keep the last strobed one
   logic        rx_hold;
   wire         rx_cur      = rx_bit_valid ? rx_bit : rx_hold;
   wire         rx_eff      = dial_clamp | rx_cur;

   // space check and blanking
   logic [11:0] blank_ms;
   wire check_on = m_local | m_lrx | (m_ltx & ctrl.duplex);
   wire space    = check_on & rx_bit_valid & ~rx_eff;

   // rts to cts
   wire rts_src  = clamp ? (m_local | m_ltx | (m_lrx & ctrl.duplex)) : rts_in;
   logic        rts_q;
   logic        first_cts;
   logic [11:0] cts_ms;
   logic        cts_run;
   logic        cts_int;
   logic [11:0] extra_ms;

   always_comb
   begin
      extra_ms = 12'h000;
      if (first_cts && ctrl.long_initial_cts && ctrl.auto_equalizer)
         extra_ms = mtm_pkg::AEQ_EXTRA_MS;
      else if (first_cts && ctrl.long_initial_cts && ctrl.standby_backup_feature)
         extra_ms = mtm_pkg::STANDBY_BACKUP_FEATURE_LONG_MS;
      else if (!ctrl.long_initial_cts && ctrl.standby_backup_feature)
         extra_ms = mtm_pkg::STANDBY_BACKUP_FEATURE_SHORT_MS;
   end

   wire [11:0] cts_load = {4'h0, ctrl.cts_delay_straps} + extra_ms;

   // resync settling after any mode change with auto equalizer on
   logic [11:0] settle_ms;

   // next values of the outputs
   logic next_tx_bit;
   logic next_dsr;
   logic next_ready;

   always_comb
   begin
      if (m_local || m_ltx)
         next_tx_bit = 1'b1;
      else if (m_lrx)
         next_tx_bit = ctrl.duplex ? rx_eff : 1'b1;
      else
         next_tx_bit = txd_in;
   end

   assign next_dsr   = ~clamp;
   assign next_ready = next_dsr & ~(m_term & sw_term);

   // register file and ahb response
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl      <= 24'(mtm_pkg::CTRL_RESET);
         wr_pend   <= 1'b0;
         wr_ofs    <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         wr_pend <= take & hwrite;
         if (take)
            wr_ofs <= a_ofs;
         if (wr_ctrl)
            ctrl <= 24'(hwdata & mtm_pkg::CTRL_MASK);
         if (take && !hwrite)
         begin
            unique case (a_ofs)
               mtm_pkg::CTRL_OFS:   hrdata <= {8'h00, ctrl};
               mtm_pkg::STATUS_OFS: hrdata <= {20'h00000, cts_run, dial_clamp,
                                               ready_ind, operate_ind, resync_ctrl,
                                               eq_enable, wrap_relay, clamp,
                                               1'b0, mode_q};
               mtm_pkg::SPACE_OFS:  hrdata <= {16'h0000, space_cnt};
               default:             hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // timers and mode tracking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pre_cnt    <= 32'h0000_0000;
         mode_q     <= mtm_pkg::MODE_OPERATE;
         dial_ms    <= 12'h000;
         dial_clamp <= 1'b0;
         blank_ms   <= 12'h000;
         space_cnt  <= 16'h0000;
         settle_ms  <= 12'h000;
         rx_hold    <= 1'b1;
      end
      else
      begin
         pre_cnt <= ms_tick ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
         mode_q  <= mode;
         if (rx_bit_valid)
            rx_hold <= rx_bit;

         // detector must hold before the clamp engages
         if (!dial_active)
         begin
            dial_ms    <= 12'h000;
            dial_clamp <= 1'b0;
         end
         else if (ms_tick && !dial_clamp)
         begin
            if (dial_ms >= DIAL_QUAL_MS - 12'h001)
               dial_clamp <= 1'b1;
            else
               dial_ms <= dial_ms + 12'h001;
         end

         if (space)
            blank_ms <= mtm_pkg::BLANK_MS;
         else if (ms_tick && blank_ms != 12'h000)
            blank_ms <= blank_ms - 12'h001;

         // a space coincident with a clearing write is counted after the clear
         if (space)
            space_cnt <= wr_space ? 16'h0001 : space_cnt + 16'h0001;
         else if (wr_space)
            space_cnt <= 16'h0000;

         if (mode_chg && ctrl.auto_equalizer)
            settle_ms <= mtm_pkg::AEQ_SETTLE_MS;
         else if (ms_tick && settle_ms != 12'h000)
            settle_ms <= settle_ms - 12'h001;
      end
   end

   // clear-to-send sequencing
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rts_q     <= 1'b0;
         first_cts <= 1'b1;
         cts_ms    <= 12'h000;
         cts_run   <= 1'b0;
         cts_int   <= 1'b0;
      end
      else
      begin
         rts_q <= rts_src;
         if (!rts_src)
         begin
            cts_run <= 1'b0;
            cts_int <= 1'b0;
         end
         else if (!rts_q)
         begin
            cts_ms  <= cts_load;
            cts_run <= 1'b1;
         end
         // expiry waits for a full tick so the delay never runs short of the straps
         else if (cts_run && ms_tick)
         begin
            if (cts_ms == 12'h000)
            begin
               cts_run <= 1'b0;
               cts_int <= 1'b1;
            end
            else
               cts_ms <= cts_ms - 12'h001;
         end
         // long initial delay only for the first cts after reset or a mode change
         if (mode_chg)
            first_cts <= 1'b1;
         else if (cts_run && cts_ms == 12'h000 && ms_tick)
            first_cts <= 1'b0;
      end
   end

   // registered outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dte_cts     <= 1'b0;
         dte_dsr     <= 1'b0;
         dte_dcd     <= 1'b0;
         dte_rx_data <= 1'b1;
         tx_bit      <= 1'b1;
         tx_rts      <= 1'b0;
         wrap_relay  <= 1'b0;
         eq_enable   <= 1'b0;
         resync_ctrl <= 1'b1;
         operate_ind <= 1'b0;
         ready_ind   <= 1'b0;
      end
      else
      begin
         // cts falls with the request at once, on the same edge that clears the timer flag
         dte_cts     <= cts_int & rts_src & ~clamp;
         dte_dsr     <= next_dsr;
         dte_dcd     <= carrier_det & ~clamp;
         dte_rx_data <= clamp | rx_eff;
         tx_bit      <= next_tx_bit;
         tx_rts      <= rts_src;
         wrap_relay  <= loop;
         eq_enable   <= ~loop & ~((m_ltx | m_lrx) & ctrl.rate_1200);
         resync_ctrl <= (settle_ms != 12'h000) | carrier_det;
         operate_ind <= (blank_ms == 12'h000) & ~space;
         ready_ind   <= next_ready;
      end
   end

endmodule // mtm_top

// ==== sim/mtm_chk.sv ====
// mtm_chk: port-level assertions for mtm_top
// assumes it is bound into mtm_top and shares its MS_CYCLES
`timescale 1ns/1ps
module mtm_chk #(
   parameter int unsigned MS_CYCLES = 10
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hreadyout,
   input wire logic hresp,
   // terminal
   input wire logic dte_rts,
   input wire logic dte_cts,
   input wire logic dte_dsr,
   input wire logic dte_dcd,
   input wire logic dte_rx_data,
   // modem
   input wire logic rx_bit,
   input wire logic rx_bit_valid,
   input wire logic tx_bit,
   input wire logic tx_rts,
   input wire logic wrap_relay,
   input wire logic eq_enable,
   input wire logic operate_ind
);
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   localparam int unsigned MIN_LOW = 148 * MS_CYCLES;
   localparam int unsigned MAX_LOW = 153 * MS_CYCLES;
   // cycles since a space arrived while the terminal was clamped
   logic [31:0] quiet;
   wire logic   loop1 = wrap_relay & ~dte_dsr;
   wire logic   space = rx_bit_valid & ~rx_bit & ~dte_dsr;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         quiet <= 32'hFFFF_FFFF;
      else if (space)
         quiet <= 32'h0000_0000;
      else if (quiet != 32'hFFFF_FFFF)
         quiet <= quiet + 32'h0000_0001;
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus wait or error response");
   loop_mark_a: assert property (loop1 && $past(loop1) |-> tx_bit && tx_rts)
      else $error("local loop not sending mark pattern");
   lit_steady_a: assert property (!dte_dsr && tx_rts && quiet > MAX_LOW |-> operate_ind)
      else $error("operate dark with no space");
   blank_start_a: assert property (loop1 && rx_bit_valid && !rx_bit |=> !operate_ind [*8])
      else $error("space did not blank operate");
   blank_full_a: assert property ($rose(operate_ind) |-> quiet >= MIN_LOW)
      else $error("blanking ended early");
   dte_clamp_a: assert property (!dte_dsr && !$past(dte_dsr) |-> !dte_cts && !dte_dcd && dte_rx_data)
      else $error("terminal not clamped");
   loop_eq_a: assert property (wrap_relay && $past(wrap_relay) |-> !eq_enable)
      else $error("equalizer on in loop");
   cts_rts_a: assert property ($rose(dte_cts) |-> dte_rts && $past(dte_rts, 5))
      else $error("cts without request");
endmodule // mtm_chk

bind mtm_top mtm_chk #(.MS_CYCLES(MS_CYCLES)) mtm_chk_inst (
   .hclk, .hresetn, .hreadyout, .hresp, .dte_rts, .dte_cts, .dte_dsr, .dte_dcd, .dte_rx_data,
   .rx_bit, .rx_bit_valid, .tx_bit, .tx_rts, .wrap_relay, .eq_enable, .operate_ind
);

// ==== sim/mtm_far.sv ====
// mtm_far: remote modem and demodulator feeding the receive side
// assumes space_req pulses one cycle; one bit strobe every 4 cycles
`timescale 1ns/1ps
module mtm_far (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // from the block
   input  wire logic tx_bit,
   input  wire logic tx_rts,
   input  wire logic wrap_relay,
   // bench commands
   input  wire logic space_req,
   input  wire logic line_carrier,
   // to the block
   output logic      rx_bit,
   output logic      rx_bit_valid,
   output logic      carrier_det
);
   logic [1:0] phase;
   logic       pend;
   // remote sends steady mark; wrapped data comes straight back
   wire logic  line_bit = (wrap_relay ? tx_bit : 1'b1) & ~pend;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         phase        <= 2'h0;
         pend         <= 1'b0;
         rx_bit       <= 1'b1;
         rx_bit_valid <= 1'b0;
      end
      else
      begin
         phase        <= phase + 2'h1;
         rx_bit_valid <= phase == 2'h3;
         // between strobes the bit is junk, so it toggles
         rx_bit       <= phase == 2'h3 ? line_bit : ~rx_bit;
         pend         <= space_req | (pend & phase != 2'h3);
      end
   assign carrier_det = wrap_relay ? tx_rts : line_carrier;
endmodule // mtm_far

// ==== sim/test_modem_test_mode_control.sv ====
// test_modem_test_mode_control: self-checking bench for mtm_top
// assumes mtm_chk bound in, mtm_far on the line side, 1 ms = 10 cycles
`timescale 1ns/1ps
module test_modem_test_mode_control;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        dte_rts, dte_tx_data, dte_test_line, dial_tone_pin, space_req, line_carrier;
   logic        dte_cts, dte_dsr, dte_dcd, dte_rx_data, rx_bit, rx_bit_valid, carrier_det;
   logic        tx_bit, tx_rts, wrap_relay, eq_enable, resync_ctrl, operate_ind, ready_ind;
   logic [31:0] haddr, hwdata, hrdata, rdat, w;
   logic [1:0]  htrans;
   logic [2:0]  hsize, lo;
   logic [5:0]  cfg [3] = '{6'h10, 6'h18, 6'h16};
   int          xms [3] = '{0, 30, 980};
   int          err_count, checks_done, n, dly, sp_exp;
   mtm_top #(.MS_CYCLES(10), .DIAL_QUAL_MS(12'h002)) mtm_top_inst (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .dte_rts, .dte_tx_data, .dte_test_line, .dte_cts, .dte_dsr,
      .dte_dcd, .dte_rx_data, .rx_bit, .rx_bit_valid, .carrier_det, .dial_tone_pin, .tx_bit,
      .tx_rts, .wrap_relay, .eq_enable, .resync_ctrl, .operate_ind, .ready_ind);
   mtm_far mtm_far_inst (.hclk, .hresetn, .tx_bit, .tx_rts, .wrap_relay, .space_req,
      .line_carrier, .rx_bit, .rx_bit_valid, .carrier_det);
   // {wrap, ready to terminal, send bit, transmitter on} per switch position
   function automatic logic [3:0] model(input int m);
      return {m == 1 || m == 2, m == 0 || m == 2, m != 0 && m != 2, 1'b1};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      haddr  <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsel   <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask
   task automatic setc(input int m, input logic [5:0] f);
      bus(1'b1, mtm_pkg::CTRL_OFS, {8'h00, 8'(dly), 7'h00, f, 3'(m)});
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask
   task automatic spc();
      sp_exp++;
      space_req <= 1'b1;
      @(posedge hclk);
      space_req <= 1'b0;
   endtask
   // lows seen on {operate, send bit, terminal data} over 12 cycles
   task automatic watch();
      lo = 3'h0;
      repeat (12)
      begin
         @(posedge hclk);
         lo |= ~{operate_ind, tx_bit, dte_rx_data};
      end
   endtask
   task automatic wait_op(input logic v);
      n = 0;
      while (operate_ind !== v && n < 20000)
      begin
         @(posedge hclk);
         n++;
      end
      chk(operate_ind, v);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   initial
   begin
      #250_000;
      err_count++;
      wrap_up();
   end
   initial
   begin
      {hresetn, hsel, hwrite, dte_rts, dte_test_line, dial_tone_pin, space_req} = 7'h00;
      {dte_tx_data, line_carrier} = 2'h3;
      {haddr, hwdata, htrans} = 66'h0;
      hsize = 3'h2;
      dly = 2;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      w = $urandom(32'hBFF5CD69);
      bus(1'b1, mtm_pkg::CTRL_OFS, w);
      bus(1'b0, mtm_pkg::CTRL_OFS, 32'h0);
      chk(rdat, w & mtm_pkg::CTRL_MASK);
      bus(1'b0, 8'h0C, 32'h0);
      chk(rdat, 32'h0);
      $display("registers done");
      dte_rts <= 1'b1;
      dte_tx_data <= 1'b0;
      for (int r = 0; r < 2; r++)
         for (int m = 0; m < 5; m++)
         begin
            setc(m, {r[0], 5'h10});
            cyc(8);
            chk({wrap_relay, dte_dsr, tx_bit, tx_rts}, model(m));
            if (m != 0) chk(eq_enable, m > 2 && r == 0);
            if (m != 0 && m != 2) chk({dte_cts, dte_dcd, dte_rx_data}, 3'h1);
            if (m == 0 || m == 2) chk(ready_ind, m == 0);
         end
      for (int k = 0; k < 2; k++)
      begin
         setc(k ? 0 : 2, 6'h10);
         dte_test_line <= k[0];
         dte_tx_data <= 1'b0;
         cyc(16);
         chk({wrap_relay, dte_dsr, eq_enable, ready_ind}, {3'h6, k[0]});
         chk(dte_rx_data, 1'b0);
         dte_tx_data <= 1'b1;
         cyc(16);
         chk(dte_rx_data, 1'b1);
      end
      dte_test_line <= 1'b0;
      $display("modes done");
      setc(1, 6'h10);
      wait_op(1'b1);
      cyc(20);
      chk(operate_ind, 1'b1);
      bus(1'b1, mtm_pkg::SPACE_OFS, 32'h0);
      sp_exp = 0;
      spc();
      wait_op(1'b0);
      chk(n < 8, 1'b1);
      cyc(1000);
      spc();
      wait_op(1'b1);
      chk(n > 1470 && n < 1530, 1'b1);
      bus(1'b0, mtm_pkg::SPACE_OFS, 32'h0);
      chk(rdat, sp_exp);
      $display("blanking done");
      for (int m = 3; m < 5; m++)
      begin
         setc(m, 6'h10);
         cyc(20);
         spc();
         watch();
         chk(lo[2], 1'b1);
         if (m == 4) chk(lo[1], 1'b1);
         wait_op(1'b1);
      end
      for (int k = 0; k < 2; k++)
      begin
         setc(0, 6'h11);
         dial_tone_pin <= !k[0];
         cyc(60);
         spc();
         watch();
         chk(lo[0], k[0]);
      end
      $display("line tests done");
      for (int i = 0; i < 3; i++)
      begin
         dly = $urandom_range(9, 2);
         dte_rts <= 1'b0;
         line_carrier <= 1'b0;
         setc(1, cfg[i]);
         setc(0, cfg[i]);
         cyc(10);
         dte_rts <= 1'b1;
         n = 0;
         while (dte_cts !== 1'b1 && n < 20000)
         begin
            @(posedge hclk);
            n++;
            if (n == 7700 && cfg[i][2]) chk(resync_ctrl, 1'b1);
            if (n == 8200 || (n == 40 && !cfg[i][2])) chk(resync_ctrl, carrier_det);
         end
         chk(n >= (dly + xms[i]) * 10 && n <= (dly + xms[i]) * 10 + 20, 1'b1);
      end
      $display("cts done");
      wrap_up();
   end
endmodule // test_modem_test_mode_control
